// file: include/dpu_map.vh
`ifndef DPU_MAP_VH
`define DPU_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define DPU_IDX_BUF_END     8'he3
`define DPU_IDX_PCFG        8'hd0
`define DPU_IDX_MODE        8'hd1
`define DPU_IDX_PTR0_LO     8'hd2
`define DPU_IDX_PTR0_HI     8'hd3
`define DPU_IDX_PTR1_LO     8'hd4
`define DPU_IDX_PTR1_HI     8'hd5

// ----------------------------------------------------------------
// pointer_config field positions
// ----------------------------------------------------------------
`define DPU_PCFG_SEL        0
`define DPU_PCFG_SIG        3
`define DPU_PCFG_DEC0       4
`define DPU_PCFG_DEC1       5
`define DPU_PCFG_AU0        6
`define DPU_PCFG_AU1        7
`define DPU_PCFG_WMASK      8'hf9

// ----------------------------------------------------------------
// pointer_mode_register field positions
// ----------------------------------------------------------------
`define DPU_MODE_RDB        0
`define DPU_MODE_IDXDIS     1
`define DPU_MODE_CIRC0      2
`define DPU_MODE_CIRC1      3
`define DPU_MODE_WMASK      8'h0f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DPU_RST_PCFG        8'h00
`define DPU_RST_MODE        8'h00
`define DPU_RST_BUF_END     8'h00
`define DPU_RST_PTR         16'h0000

// ----------------------------------------------------------------
// Circular buffer bases
// ----------------------------------------------------------------
`define DPU_BASE_A          8'h00
`define DPU_BASE_B          8'h01

// ----------------------------------------------------------------
// Decoder operation codes
// ----------------------------------------------------------------
`define DPU_OP_LOAD         3'h0
`define DPU_OP_INC          3'h1
`define DPU_OP_XRD          3'h2
`define DPU_OP_XWR          3'h3
`define DPU_OP_CODE         3'h4
`define DPU_OP_CODE_IDX     3'h5
`define DPU_OP_JMP_IDX      3'h6

`endif

// file: logic/dpu_core.v
// Behaviour
// - Select bit zero: plain refs use pointer zero, alternate refs pointer one; one swaps.
// - Per-pointer decrement bit turns pointer increment into decrement for that pointer.
// - Auto-update bit post-steps pointer on data and code moves, direction by decrement bit.
// - Auto-update clear: data and code moves leave the pointer unchanged.
// - Signature enable steers pointer code reads and programming accesses to signature array.
// - Redirect-to-B: moves through pointer one use B; pointer zero keeps accumulator.
// - Redirect changes only the destination, never the index register of code reads.
// - Index disable: indexed code read uses pointer alone, no accumulator added.
// - Each pointer has its own circular enable, independent of the other.
// - Buffer A spans 0000H to end value; buffer B 0100H to 100H plus end.
// - Buffer length comes from 8-bit end register at E3H, up to 256 entries.
// - Circular increment at end value loads 0000H; at 100H plus end loads 0100H.
// - Circular decrement at 0000H loads end value; at 0100H loads 100H plus end.
// - Wrapping applies to explicit increments and auto post-updates alike.
// - Away from boundaries circular pointers step as ordinary 16-bit values.
// - Prefixed pointer instructions except indexed jump use the inverse select bit.
`timescale 1ns/1ps
`include "dpu_map.vh"

module dpu_core #(
    parameter ADR_W = 10
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Wishbone slave
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [ADR_W-1:0] wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    // Instruction decoder
    input  wire             op_valid_i,
    input  wire [2:0]       op_kind_i,
    input  wire             op_alt_i,
    input  wire [15:0]      op_data_i,
    input  wire [7:0]       acc_i,
    // Memory access issue
    output reg              mem_valid_o,
    output reg  [15:0]      mem_addr_o,
    output reg              mem_write_o,
    output reg              mem_code_o,
    output reg              mem_sig_o,
    output reg              use_b_o,
    // Indexed jump target
    output reg              jmp_valid_o,
    output reg  [15:0]      jmp_addr_o,
    // Programming access target
    output wire             iap_sig_o
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg  [7:0]  pointer_config;
    reg  [7:0]  pointer_mode_register;
    reg  [7:0]  circular_buffer_end;
    reg  [15:0] pointer_zero;
    reg  [15:0] pointer_one;

    reg  [15:0] next_pointer_zero;
    reg  [15:0] next_pointer_one;
    reg  [7:0]  rd_byte;

    wire [15:0] step_zero;
    wire [15:0] step_one;

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    // Plain views of the stored bits; unwritable bits were masked on the way in
    wire pointer_select       = pointer_config[`DPU_PCFG_SEL];
    wire signature_enable     = pointer_config[`DPU_PCFG_SIG];
    wire ptr0_decrement       = pointer_config[`DPU_PCFG_DEC0];
    wire ptr1_decrement       = pointer_config[`DPU_PCFG_DEC1];
    wire ptr0_auto_update     = pointer_config[`DPU_PCFG_AU0];
    wire ptr1_auto_update     = pointer_config[`DPU_PCFG_AU1];
    wire redirect_to_b        = pointer_mode_register[`DPU_MODE_RDB];
    wire index_disable        = pointer_mode_register[`DPU_MODE_IDXDIS];
    wire ptr0_circular_enable = pointer_mode_register[`DPU_MODE_CIRC0];
    wire ptr1_circular_enable = pointer_mode_register[`DPU_MODE_CIRC1];

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // A held strobe is taken once: an ack in flight blocks a second take
    wire       bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire       bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
    wire [7:0] bus_idx = wb_adr_i[9:2];
    wire [7:0] bus_dat = wb_dat_i[7:0];

    // Register hit for a given index
    function hit;
        input [7:0] idx;
        input [7:0] want;
        begin
            hit = (idx == want);
        end
    endfunction

    // ----------------------------------------------------------------
    // Operation decode
    // ----------------------------------------------------------------
    // Kind 7 is unused: it issues nothing and moves no pointer
    wire is_load  = op_kind_i == `DPU_OP_LOAD;
    wire is_inc   = op_kind_i == `DPU_OP_INC;
    wire is_jmp   = op_kind_i == `DPU_OP_JMP_IDX;
    wire is_xmove = (op_kind_i == `DPU_OP_XRD) || (op_kind_i == `DPU_OP_XWR);
    wire is_cmove = (op_kind_i == `DPU_OP_CODE) || (op_kind_i == `DPU_OP_CODE_IDX);
    wire is_move  = is_xmove || is_cmove;

    // The indexed jump ignores the prefix and always uses the plain pointer
    wire use_one  = pointer_select ^ (op_alt_i && !is_jmp);
    wire [15:0] sel_ptr = use_one ? pointer_one : pointer_zero;

    // Code read index: accumulator unless indexing is disabled
    // Redirect never reaches here: the index is the accumulator whatever the redirect bit
    wire [15:0] code_idx = (op_kind_i == `DPU_OP_CODE_IDX && !index_disable) ?
                           {8'h00, acc_i} : 16'h0000;

    // A pointer steps on its own increment, or on a move when its auto-update bit is set
    function wants_step;
        input valid;
        input mine;
        input inc;
        input move;
        input upd;
        begin
            wants_step = valid && mine && (inc || (move && upd));
        end
    endfunction

    // Which pointer steps this cycle; only the addressed one ever moves
    wire step0 = wants_step(op_valid_i, !use_one, is_inc, is_move, ptr0_auto_update);
    wire step1 = wants_step(op_valid_i, use_one, is_inc, is_move, ptr1_auto_update);
    wire load0 = op_valid_i && is_load && !use_one;
    wire load1 = op_valid_i && is_load && use_one;

    // ----------------------------------------------------------------
    // Step units, one per pointer
    // ----------------------------------------------------------------
    // Same unit serves explicit increments and post-updates
    dpu_step u_step_zero (
        .ptr_i     (pointer_zero),
        .dec_i     (ptr0_decrement),
        .circ_i    (ptr0_circular_enable),
        .buf_end_i (circular_buffer_end),
        .next_o    (step_zero)
    );

    dpu_step u_step_one (
        .ptr_i     (pointer_one),
        .dec_i     (ptr1_decrement),
        .circ_i    (ptr1_circular_enable),
        .buf_end_i (circular_buffer_end),
        .next_o    (step_one)
    );

    // ----------------------------------------------------------------
    // Pointer next values
    // ----------------------------------------------------------------
    // Next value of one pointer: load, else step, then any bus byte write on top
    function [15:0] ptr_next;
        input [15:0] cur;
        input        load;
        input [15:0] load_val;
        input        step;
        input [15:0] step_val;
        input        wr_lo;
        input        wr_hi;
        input [7:0]  dat;
        reg   [15:0] val;
        begin
            val = cur;
            if (load) begin
                val = load_val;                                      // Loads bypass the wrap logic
            end else if (step) begin
                val = step_val;
            end
            if (wr_lo) begin
                val[7:0] = dat;
            end
            if (wr_hi) begin
                val[15:8] = dat;
            end
            ptr_next = val;
        end
    endfunction

    // Bus byte writes override a same-cycle instruction update
    always @* begin
        next_pointer_zero = ptr_next(pointer_zero, load0, op_data_i, step0, step_zero,
                                     bus_wr && hit(bus_idx, `DPU_IDX_PTR0_LO),
                                     bus_wr && hit(bus_idx, `DPU_IDX_PTR0_HI), bus_dat);
    end

    // Same merge for the other pointer; each pointer has its own byte pair
    always @* begin
        next_pointer_one = ptr_next(pointer_one, load1, op_data_i, step1, step_one,
                                    bus_wr && hit(bus_idx, `DPU_IDX_PTR1_LO),
                                    bus_wr && hit(bus_idx, `DPU_IDX_PTR1_HI), bus_dat);
    end

    // Pointer registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            pointer_zero <= `DPU_RST_PTR;
            pointer_one  <= `DPU_RST_PTR;
        end else begin
            pointer_zero <= next_pointer_zero;
            pointer_one  <= next_pointer_one;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Bits 2 and 1 of pointer_config are not stored and read as zero
    // Mode bits above bit 3 are not stored either, so reads never show stale writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            pointer_config        <= `DPU_RST_PCFG;
            pointer_mode_register <= `DPU_RST_MODE;
            circular_buffer_end   <= `DPU_RST_BUF_END;
        end else if (bus_wr) begin
            if (hit(bus_idx, `DPU_IDX_PCFG)) begin
                pointer_config <= bus_dat & `DPU_PCFG_WMASK;
            end
            if (hit(bus_idx, `DPU_IDX_MODE)) begin
                pointer_mode_register <= bus_dat & `DPU_MODE_WMASK;
            end
            if (hit(bus_idx, `DPU_IDX_BUF_END)) begin
                circular_buffer_end <= bus_dat;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus read and acknowledge
    // ----------------------------------------------------------------
    // Unmapped indices read zero and ignore writes
    always @* begin
        case (bus_idx)
            `DPU_IDX_PCFG:    rd_byte = pointer_config;
            `DPU_IDX_MODE:    rd_byte = pointer_mode_register;
            `DPU_IDX_BUF_END: rd_byte = circular_buffer_end;
            `DPU_IDX_PTR0_LO: rd_byte = pointer_zero[7:0];
            `DPU_IDX_PTR0_HI: rd_byte = pointer_zero[15:8];
            `DPU_IDX_PTR1_LO: rd_byte = pointer_one[7:0];
            `DPU_IDX_PTR1_HI: rd_byte = pointer_one[15:8];
            default:          rd_byte = 8'h00;
        endcase
    end

    // One wait-free answer: ack one cycle after the strobe, then dropped
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                wb_dat_o <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ----------------------------------------------------------------
    // Memory access and jump issue
    // ----------------------------------------------------------------
    // Address uses the pointer value before its post-update
    // Address and flags hold until the next move, so a slow consumer may read late
    always @(posedge clk_i) begin
        if (rst_i) begin
            mem_valid_o <= 1'b0;
            mem_addr_o  <= 16'h0000;
            mem_write_o <= 1'b0;
            mem_code_o  <= 1'b0;
            mem_sig_o   <= 1'b0;
            use_b_o     <= 1'b0;
            jmp_valid_o <= 1'b0;
            jmp_addr_o  <= 16'h0000;
        end else begin
            mem_valid_o <= op_valid_i && is_move;
            jmp_valid_o <= op_valid_i && is_jmp;
            if (op_valid_i && is_move) begin
                mem_addr_o  <= sel_ptr + code_idx;
                mem_write_o <= op_kind_i == `DPU_OP_XWR;
                mem_code_o  <= is_cmove;
                mem_sig_o   <= is_cmove && signature_enable;
                use_b_o     <= redirect_to_b && use_one;
            end
            if (op_valid_i && is_jmp) begin
                jmp_addr_o <= sel_ptr + {8'h00, acc_i};
            end
        end
    end

    // Programming accesses follow the signature enable bit directly
    assign iap_sig_o = signature_enable;

endmodule // dpu_core

// file: logic/dpu_step.v
`timescale 1ns/1ps
`include "dpu_map.vh"

// One step of a pointer: +1 or -1, with circular wrap at buffer bounds
module dpu_step (
    // Pointer and controls
    input  wire [15:0] ptr_i,
    input  wire        dec_i,
    input  wire        circ_i,
    input  wire [7:0]  buf_end_i,
    // Stepped value
    output reg  [15:0] next_o
);

    wire [15:0] end_a  = {`DPU_BASE_A, buf_end_i};
    wire [15:0] end_b  = {`DPU_BASE_B, buf_end_i};
    wire [15:0] base_a = {`DPU_BASE_A, 8'h00};
    wire [15:0] base_b = {`DPU_BASE_B, 8'h00};

    // Boundary wrap first, ordinary 16-bit step everywhere else
    always @* begin
        if (circ_i && !dec_i && ptr_i == end_a) begin
            next_o = base_a;
        end else if (circ_i && !dec_i && ptr_i == end_b) begin
            next_o = base_b;
        end else if (circ_i && dec_i && ptr_i == base_a) begin
            next_o = end_a;
        end else if (circ_i && dec_i && ptr_i == base_b) begin
            next_o = end_b;
        end else if (dec_i) begin
            next_o = ptr_i - 16'h0001;
        end else begin
            next_o = ptr_i + 16'h0001;
        end
    end

endmodule // dpu_step

// file: tb/dpu_core_checker.sv
`timescale 1ns/1ps
`include "dpu_map.vh"
// ----------------------------------------------------------------
// Port checker for the pointer unit
// ----------------------------------------------------------------
module dpu_core_checker (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Register bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Decoder and issue
    input wire        op_valid_i,
    input wire [2:0]  op_kind_i,
    input wire        mem_valid_o,
    input wire        mem_write_o,
    input wire        mem_code_o,
    input wire        mem_sig_o,
    input wire        jmp_valid_o,
    input wire        iap_sig_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Move request of kinds two to five
    wire mv = op_valid_i && op_kind_i >= `DPU_OP_XRD && op_kind_i <= `DPU_OP_CODE_IDX;
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    move_issue_a: assert property (mv |=> mem_valid_o)
        else $error("move not issued");
    no_issue_a: assert property (!mv |=> !mem_valid_o)
        else $error("access issued without move");
    write_dir_a: assert property (mv |=> mem_write_o == ($past(op_kind_i) == `DPU_OP_XWR))
        else $error("access direction wrong");
    code_flag_a: assert property (mv |=> mem_code_o == ($past(op_kind_i) >= `DPU_OP_CODE))
        else $error("code flag wrong");
    sig_follow_a: assert property (mem_valid_o && mem_code_o |-> mem_sig_o == $past(iap_sig_o))
        else $error("signature target wrong");
    jump_only_a: assert property (jmp_valid_o |-> $past(op_valid_i) && $past(op_kind_i) == `DPU_OP_JMP_IDX)
        else $error("jump without jump op");
    cover property (mem_valid_o && mem_code_o && mem_sig_o);
    cover property (mem_valid_o && mem_write_o);
    cover property (jmp_valid_o);
endmodule // dpu_core_checker

bind dpu_core dpu_core_checker dpu_core_checker_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .op_valid_i, .op_kind_i, .mem_valid_o, .mem_write_o, .mem_code_o, .mem_sig_o,
    .jmp_valid_o, .iap_sig_o);

// file: tb/tb.sv
`timescale 1ns/1ps
`include "dpu_map.vh"
module tb;
    logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, op_valid_i = 0, op_alt_i = 0;
    logic [9:0]  wb_adr_i = '0;
    logic [3:0]  wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0, q;
    logic [2:0]  op_kind_i = '0;
    logic [15:0] op_data_i = '0;
    logic [7:0]  acc_i = 8'h10;
    wire  [31:0] wb_dat_o;
    wire  [15:0] mem_addr_o, jmp_addr_o;
    wire         wb_ack_o, mem_valid_o, mem_write_o, mem_code_o, mem_sig_o, use_b_o, jmp_valid_o, iap_sig_o;
    int          failures = 0, checks_done = 0;
    // 100 MHz clock
    always #5 clk_i = ~clk_i;
    dpu_core #(.ADR_W(10)) dpu_core_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .op_valid_i, .op_kind_i, .op_alt_i, .op_data_i, .acc_i, .mem_valid_o,
        .mem_addr_o, .mem_write_o, .mem_code_o, .mem_sig_o, .use_b_o, .jmp_valid_o, .jmp_addr_o, .iap_sig_o);
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Classic cycle: hold until ack is sampled, then release
    task wb(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= {i, 2'b00};
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        wb(1'b1, i, d, 4'h1);
    endtask
    task rchk(input logic [7:0] i, input logic [31:0] e);
        wb(1'b0, i, 8'h00, 4'hf);
        chk("register", q, e);
    endtask
    // One decoder pulse; outputs settled on return
    task op(input logic [2:0] k, input logic a, input logic [15:0] d);
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        op_kind_i <= k;
        op_alt_i <= a;
        op_data_i <= d;
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        #1;
    endtask
    task pchk(input logic n, input logic [15:0] e);
        logic [7:0] lo;
        wb(1'b0, n ? `DPU_IDX_PTR1_LO : `DPU_IDX_PTR0_LO, 8'h00, 4'hf);
        lo = q[7:0];
        wb(1'b0, n ? `DPU_IDX_PTR1_HI : `DPU_IDX_PTR0_HI, 8'h00, 4'hf);
        chk("pointer", {16'h0, q[7:0], lo}, {16'h0, e});
    endtask
    // Load pointer zero, step it once, compare
    task cs(input logic [7:0] c, input logic [15:0] s, input logic [15:0] e);
        wr(`DPU_IDX_PCFG, c);
        op(`DPU_OP_LOAD, 1'b0, s);
        op(`DPU_OP_INC, 1'b0, 16'h0);
        pchk(1'b0, e);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_regs;
        rchk(`DPU_IDX_PCFG, 32'h0);
        rchk(`DPU_IDX_MODE, 32'h0);
        pchk(1'b1, 16'h0);
        wr(`DPU_IDX_PCFG, 8'hff);
        rchk(`DPU_IDX_PCFG, 32'hf9);
        chk("iap sig", iap_sig_o, 1);
        wr(`DPU_IDX_MODE, 8'hff);
        rchk(`DPU_IDX_MODE, 32'h0f);
        wr(`DPU_IDX_BUF_END, 8'ha5);
        wb(1'b1, `DPU_IDX_BUF_END, 8'h11, 4'he);
        rchk(`DPU_IDX_BUF_END, 32'ha5);
        wr(8'h10, 8'h55);
        rchk(8'h10, 32'h0);
        wr(`DPU_IDX_PCFG, 8'h00);
        wr(`DPU_IDX_MODE, 8'h00);
        chk("iap sig", iap_sig_o, 0);
        $display("test regs done");
    endtask
    task t_sel;
        op(`DPU_OP_LOAD, 1'b0, 16'h1234);
        op(`DPU_OP_LOAD, 1'b1, 16'h5678);
        pchk(1'b0, 16'h1234);
        pchk(1'b1, 16'h5678);
        wr(`DPU_IDX_PCFG, 8'h01);
        op(`DPU_OP_LOAD, 1'b0, 16'h9abc);
        pchk(1'b1, 16'h9abc);
        op(`DPU_OP_XRD, 1'b1, 16'h0);
        chk("mem addr", mem_addr_o, 16'h1234);
        op(`DPU_OP_JMP_IDX, 1'b1, 16'h0);
        chk("jmp addr", jmp_addr_o, 16'h9acc);
        $display("test select done");
    endtask
    task t_inc;
        wr(`DPU_IDX_PCFG, 8'h10);
        op(`DPU_OP_LOAD, 1'b0, 16'h0000);
        op(`DPU_OP_LOAD, 1'b1, 16'hffff);
        op(`DPU_OP_INC, 1'b0, 16'h0);
        pchk(1'b0, 16'hffff);
        op(`DPU_OP_INC, 1'b1, 16'h0);
        pchk(1'b1, 16'h0000);
        pchk(1'b0, 16'hffff);
        wr(`DPU_IDX_PCFG, 8'h21);
        op(`DPU_OP_INC, 1'b0, 16'h0);
        pchk(1'b1, 16'hffff);
        $display("test step done");
    endtask
    task t_auto;
        wr(`DPU_IDX_PCFG, 8'h40);
        op(`DPU_OP_LOAD, 1'b0, 16'h2000);
        op(`DPU_OP_LOAD, 1'b1, 16'h3000);
        op(`DPU_OP_XRD, 1'b0, 16'h0);
        chk("mem addr", mem_addr_o, 16'h2000);
        pchk(1'b0, 16'h2001);
        op(`DPU_OP_XWR, 1'b1, 16'h0);
        chk("mem write", mem_write_o, 1);
        pchk(1'b1, 16'h3000);
        wr(`DPU_IDX_PCFG, 8'h58);
        op(`DPU_OP_CODE, 1'b0, 16'h0);
        chk("mem sig", mem_sig_o, 1);
        pchk(1'b0, 16'h2000);
        $display("test auto done");
    endtask
    task t_code;
        @(posedge clk_i);
        acc_i <= 8'h23;
        wr(`DPU_IDX_PCFG, 8'h00);
        wr(`DPU_IDX_MODE, 8'h01);
        op(`DPU_OP_LOAD, 1'b0, 16'h1000);
        op(`DPU_OP_LOAD, 1'b1, 16'h4000);
        op(`DPU_OP_CODE_IDX, 1'b0, 16'h0);
        chk("use b", {use_b_o, mem_sig_o}, 0);
        op(`DPU_OP_CODE_IDX, 1'b1, 16'h0);
        chk("mem addr", mem_addr_o, 16'h4023);
        chk("use b", use_b_o, 1);
        wr(`DPU_IDX_MODE, 8'h02);
        op(`DPU_OP_CODE_IDX, 1'b1, 16'h0);
        chk("mem addr", {use_b_o, mem_addr_o}, 17'h04000);
        wr(`DPU_IDX_PCFG, 8'h08);
        op(`DPU_OP_CODE_IDX, 1'b0, 16'h0);
        chk("mem addr", {mem_sig_o, mem_addr_o}, 17'h11000);
        $display("test code done");
    endtask
    task t_circ;
        wr(`DPU_IDX_BUF_END, 8'h07);
        wr(`DPU_IDX_MODE, 8'h04);
        cs(8'h00, 16'h0007, 16'h0000);
        cs(8'h10, 16'h0000, 16'h0007);
        cs(8'h10, 16'h0100, 16'h0107);
        cs(8'h00, 16'h0107, 16'h0100);
        cs(8'h00, 16'h00ff, 16'h0100);
        cs(8'h10, 16'h0008, 16'h0007);
        cs(8'h10, 16'h0200, 16'h01ff);
        wr(`DPU_IDX_PCFG, 8'h40);
        op(`DPU_OP_LOAD, 1'b0, 16'h0007);
        op(`DPU_OP_XRD, 1'b0, 16'h0);
        pchk(1'b0, 16'h0000);
        wr(`DPU_IDX_MODE, 8'h08);
        cs(8'h00, 16'h0007, 16'h0008);
        op(`DPU_OP_LOAD, 1'b1, 16'h0007);
        op(`DPU_OP_INC, 1'b1, 16'h0);
        pchk(1'b1, 16'h0000);
        wr(`DPU_IDX_BUF_END, 8'hff);
        wr(`DPU_IDX_MODE, 8'h04);
        cs(8'h00, 16'h01ff, 16'h0100);
        $display("test circular done");
    endtask
    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_sel;
        t_inc;
        t_auto;
        t_code;
        t_circ;
        end_sim;
    end
    // Whole run needs a few hundred cycles; this is far beyond it
    initial begin
        #300000;
        failures++;
        end_sim;
    end
endmodule // tb
